/* design/quad_dac_defines.svh */
// Constants for the four-channel converter serial control block.
// Assumes it is included by bare name from design files only.
// What this block does
// - Clear low zeroes data registers and outputs; shutdown and echo edge kept
// - Serial traffic accepted only with select low
// - Lockout low ignores software shutdown
// - Code 1100 enters shutdown when unlocked
// - Shutdown floats amplifiers and reference inputs
// - Serial interface keeps working in shutdown
// - Input registers retained through shutdown
// - Transfer or direct load leaves shutdown
// - One 16-bit shift register in and out
// - Input then converter register per channel
// - Word: address, control, ten data, sub-bits
// - Shift register echoed on serial output
// - Load input, load direct, or transfer all
// - Output code unsigned 0 to 1023
// - A,B share reference one; C,D two
// - Sample on rising clock, act on select rise
// - Control 01 loads input; 11 also updates
// - 0100 transfer, 1000 load all, 0000 nothing
// - Logic output codes and echo edge codes
`ifndef QUAD_DAC_DEFINES_SVH
`define QUAD_DAC_DEFINES_SVH
`define WORD_BITS       16
`define CODE_BITS       10
`define CODE_MSB        13
`define CODE_LSB        4
`define CMD_MSB         15
`define CMD_LSB         12
`define CMD_NOP         4'h0
`define CMD_LOGIC_LOW   4'h2
`define CMD_TRANSFER    4'h4
`define CMD_LOGIC_HIGH  4'h6
`define CMD_LOAD_ALL    4'h8
`define CMD_EDGE_FALL   4'ha
`define CMD_SHUTDOWN    4'hc
`define CMD_EDGE_RISE   4'he
`define CTRL_LOAD       2'h1
`define CTRL_LOAD_UPD   2'h3
`define SETTLE_US       20
`define CLK_MHZ         50
`define SETTLE_CYCLES   (`SETTLE_US * `CLK_MHZ)
`endif

/* design/quad_dac_pkg.sv */
// Types shared by the converter control files.
// Assumes the defines header is compiled alongside.
package quad_dac_pkg;
    typedef logic [9:0] dac_code_t;
    typedef enum logic [1:0]
    {
        LINK_IDLE  = 2'b00,
        LINK_SHIFT = 2'b01
    } link_state_t;
endpackage

/* design/pin_sync.sv */
// Two-flop synchroniser with edge detection for the serial pins.
// Assumes pins are asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
    parameter int WIDTH = 3
)
(
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // First stage is read only by the second stage
    always_comb
    begin
        next_state      = state;
        next_state.meta = pin_i;
        next_state.sync = state.meta;
        next_state.prev = state.sync;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            state <= '0;
        else
            state <= next_state;
    end

    assign level_o = state.sync;
    assign rise_o  = state.sync & ~state.prev;
    assign fall_o  = ~state.sync & state.prev;
endmodule // pin_sync
`default_nettype wire

/* design/settle_timer.sv */
// Counts the output settling wait after power-up or shutdown exit.
// Assumes start_i is a one-cycle pulse on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_defines.svh"
module settle_timer
#(
    parameter int CYCLES = `SETTLE_CYCLES
)
(
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic start_i,
    output logic      settled_o
);
    typedef struct packed
    {
        logic [15:0] count;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    // Restart on every exit; reset counts as power-up
    always_comb
    begin
        next_state = state;
        if (start_i)
            next_state.count = 16'(CYCLES);
        else if (state.count != 16'h0000)
            next_state.count = state.count - 16'h0001;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            state.count <= 16'(CYCLES);
        else
            state <= next_state;
    end

    assign settled_o = (state.count == 16'h0000);
endmodule // settle_timer
`default_nettype wire

/* design/quad_dac_serial_control.sv */
// Serial command decoder and register bank of a four-channel converter.
// Assumes select, serial clock, data and clear arrive from pins; the
// serial clock is sampled by core_clk_i and must stay well below it.
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_defines.svh"
module quad_dac_serial_control
#(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
)
(
    input  wire logic                   core_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   chip_select_n_i,
    input  wire logic                   serial_clk_i,
    input  wire logic                   serial_data_i,
    input  wire logic                   clear_n_i,
    input  wire logic                   shutdown_lockout_n_i,
    output logic                        serial_echo_o,
    output logic                        user_logic_output_o,
    output quad_dac_pkg::dac_code_t     code_a_o,
    output quad_dac_pkg::dac_code_t     code_b_o,
    output quad_dac_pkg::dac_code_t     code_c_o,
    output quad_dac_pkg::dac_code_t     code_d_o,
    output logic                        amp_enable_o,
    output logic                        reference_pair_one_enable_o,
    output logic                        reference_pair_two_enable_o,
    output logic                        shutdown_o,
    output logic                        outputs_settled_o
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    pin_sync
    #(
        .WIDTH (4)
    )
    u_pin_sync
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .pin_i      ({clear_n_i, serial_data_i, serial_clk_i, chip_select_n_i}),
        .level_o    (pin_level),
        .rise_o     (pin_rise),
        .fall_o     (pin_fall)
    );

    logic select_n;
    logic select_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic data_bit;
    logic clear_n;

    assign select_n    = pin_level[0];
    assign select_rise = pin_rise[0];
    assign sclk_rise   = pin_rise[1];
    assign sclk_fall   = pin_fall[1];
    assign data_bit    = pin_level[2];
    assign clear_n     = pin_level[3];

    // Lockout only gates a command at select rise, so a plain pair suffices
    logic [1:0] lockout_sync;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            lockout_sync <= 2'b00;
        else
            lockout_sync <= {lockout_sync[0], shutdown_lockout_n_i};
    end

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed
    {
        quad_dac_pkg::link_state_t link;
        logic [`WORD_BITS-1:0]     shift;
        logic                      echo;
        logic                      echo_on_rise;
        logic                      user_logic;
        logic                      shutdown;
        logic [3:0][9:0]           input_reg;
        logic [3:0][9:0]           conv_reg;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic        exit_pulse;

    // Two-bit channel address to one-hot write strobe
    function automatic logic [3:0] channel_onehot(input logic [1:0] addr);
        channel_onehot = 4'h1 << addr;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Shift, decode and register update

    always_comb
    begin
        logic [3:0] cmd;
        logic [1:0] ctrl;
        logic [1:0] addr;
        logic [9:0] code;
        logic [3:0] hit;
        cmd        = 4'h0;
        ctrl       = 2'b00;
        addr       = 2'b00;
        code       = 10'h000;
        hit        = 4'h0;
        next_state = state;
        exit_pulse = 1'b0;

        // Link framing: idle while select high
        unique case (state.link)
            quad_dac_pkg::LINK_IDLE:
            begin
                if (!select_n)
                    next_state.link = quad_dac_pkg::LINK_SHIFT;
            end
            quad_dac_pkg::LINK_SHIFT:
            begin
                if (select_n)
                    next_state.link = quad_dac_pkg::LINK_IDLE;
            end
            default:
                next_state.link = quad_dac_pkg::LINK_IDLE;
        endcase

        // Capture MSB first on rising clock; works in shutdown too
        if (!select_n && sclk_rise)
            next_state.shift = {state.shift[`WORD_BITS-2:0], data_bit};

        // Echo the bit leaving the register on the selected edge
        if (!select_n && ((state.echo_on_rise && sclk_rise)
                          || (!state.echo_on_rise && sclk_fall)))
            next_state.echo = state.shift[`WORD_BITS-1];

        // Act on the collected word when select returns high
        if (select_rise && state.link == quad_dac_pkg::LINK_SHIFT)
        begin
            cmd  = state.shift[`CMD_MSB:`CMD_LSB];
            addr = state.shift[15:14];
            ctrl = state.shift[13:12];
            code = state.shift[`CODE_MSB-2:`CODE_LSB-2];
            hit  = channel_onehot(addr);
            if (ctrl == `CTRL_LOAD || ctrl == `CTRL_LOAD_UPD)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (hit[i])
                        next_state.input_reg[i] = code;
                end
                if (ctrl == `CTRL_LOAD_UPD)
                    next_state.conv_reg = next_state.input_reg;
            end
            else
            begin
                unique case (cmd)
                    `CMD_TRANSFER:
                    begin
                        next_state.conv_reg = state.input_reg;
                        next_state.shutdown = 1'b0;
                        exit_pulse          = state.shutdown;
                    end
                    `CMD_LOAD_ALL:
                    begin
                        for (int i = 0; i < 4; i++)
                        begin
                            next_state.input_reg[i] = code;
                            next_state.conv_reg[i]  = code;
                        end
                        next_state.shutdown = 1'b0;
                        exit_pulse          = state.shutdown;
                    end
                    `CMD_SHUTDOWN:
                    begin
                        if (lockout_sync[1])
                            next_state.shutdown = 1'b1;
                    end
                    `CMD_LOGIC_LOW:
                        next_state.user_logic = 1'b0;
                    `CMD_LOGIC_HIGH:
                        next_state.user_logic = 1'b1;
                    `CMD_EDGE_RISE:
                    begin
                        next_state.echo_on_rise = 1'b1;
                        next_state.conv_reg     = state.input_reg;
                    end
                    `CMD_EDGE_FALL:
                    begin
                        next_state.echo_on_rise = 1'b0;
                        next_state.conv_reg     = state.input_reg;
                    end
                    default:
                    begin
                        // No operation, including code 0000
                        next_state.link = quad_dac_pkg::LINK_IDLE;
                    end
                endcase
            end
        end

        // Clear pin overrides everything while low
        if (!clear_n)
        begin
            next_state           = '0;
            next_state.link      = quad_dac_pkg::LINK_IDLE;
            next_state.shutdown  = state.shutdown;
            next_state.echo_on_rise = state.echo_on_rise;
            // Shutdown is kept, so a word cut by clear must not restart the wait
            exit_pulse           = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            state <= '0;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////
    // Settling timer and outputs

    settle_timer
    #(
        .CYCLES (SETTLE_CYCLES)
    )
    u_settle_timer
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (exit_pulse),
        .settled_o  (outputs_settled_o)
    );

    // Codes come straight from converter registers, unsigned 0..1023
    assign code_a_o = state.conv_reg[0];
    assign code_b_o = state.conv_reg[1];
    assign code_c_o = state.conv_reg[2];
    assign code_d_o = state.conv_reg[3];

    // Shutdown floats amplifiers and both reference pairs
    assign amp_enable_o                = ~state.shutdown;
    assign reference_pair_one_enable_o = ~state.shutdown;
    assign reference_pair_two_enable_o = ~state.shutdown;
    assign shutdown_o                  = state.shutdown;
    assign serial_echo_o               = state.echo;
    assign user_logic_output_o         = state.user_logic;
endmodule // quad_dac_serial_control
`default_nettype wire

/* dv/quad_dac_checker.sv */
// Port assertions for the converter serial control block.
// Assumes a host keeps select high between words and holds clear low 5+ cycles.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_checker
#(
    parameter int SETTLE_CYCLES = 20
)
(
    input wire logic                    core_clk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    chip_select_n_i,
    input wire logic                    serial_clk_i,
    input wire logic                    serial_data_i,
    input wire logic                    clear_n_i,
    input wire logic                    shutdown_lockout_n_i,
    input wire logic                    serial_echo_o,
    input wire logic                    user_logic_output_o,
    input wire quad_dac_pkg::dac_code_t code_a_o,
    input wire quad_dac_pkg::dac_code_t code_b_o,
    input wire quad_dac_pkg::dac_code_t code_c_o,
    input wire quad_dac_pkg::dac_code_t code_d_o,
    input wire logic                    amp_enable_o,
    input wire logic                    reference_pair_one_enable_o,
    input wire logic                    reference_pair_two_enable_o,
    input wire logic                    shutdown_o,
    input wire logic                    outputs_settled_o
);
    // Four cycles of margin on top of the count; the timer loads in the same cycle that shutdown falls
    localparam int SETTLE_MAX = SETTLE_CYCLES + 4;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_clear;
        !clear_n_i [*5] |-> code_a_o == 10'h000 && code_b_o == 10'h000 && code_c_o == 10'h000
            && code_d_o == 10'h000 && !user_logic_output_o && !serial_echo_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left outputs set");
    property p_enables;
        amp_enable_o == !shutdown_o && reference_pair_one_enable_o == !shutdown_o
            && reference_pair_two_enable_o == !shutdown_o;
    endproperty
    a_enables: assert property (p_enables) else $error("enables disagree");
    property p_lockout;
        !shutdown_lockout_n_i [*4] ##0 !shutdown_o |=> !shutdown_o;
    endproperty
    a_lockout: assert property (p_lockout) else $error("locked shutdown");
    property p_shut_cmd;
        $rose(shutdown_o) |-> chip_select_n_i && $past(shutdown_lockout_n_i, 3);
    endproperty
    a_shut_cmd: assert property (p_shut_cmd) else $error("stray shutdown");
    // Clear excluded: it zeroes state with select in any level
    property p_change;
        ($changed(code_a_o) || $changed(user_logic_output_o) || $changed(shutdown_o))
            && clear_n_i && $past(clear_n_i, 4) |-> $past(chip_select_n_i, 2);
    endproperty
    a_change: assert property (p_change) else $error("change with select low");
    property p_settle_low;
        $fell(shutdown_o) |=> !outputs_settled_o [*8];
    endproperty
    a_settle_low: assert property (p_settle_low) else $error("settled too soon");
    property p_settle_end;
        $fell(shutdown_o) |-> ##[1:SETTLE_MAX] outputs_settled_o;
    endproperty
    a_settle_end: assert property (p_settle_end) else $error("never settled");
    property p_settle_rst;
        $fell(sys_rst_i) |-> !outputs_settled_o;
    endproperty
    a_settle_rst: assert property (p_settle_rst) else $error("settled at reset");
    c_shut: cover property ($rose(shutdown_o));
    c_exit: cover property ($fell(shutdown_o));
    c_user: cover property ($rose(user_logic_output_o));
endmodule // quad_dac_checker
bind quad_dac_serial_control quad_dac_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i
(
    .core_clk_i, .sys_rst_i, .chip_select_n_i, .serial_clk_i, .serial_data_i, .clear_n_i,
    .shutdown_lockout_n_i, .serial_echo_o, .user_logic_output_o, .code_a_o, .code_b_o,
    .code_c_o, .code_d_o, .amp_enable_o, .reference_pair_one_enable_o,
    .reference_pair_two_enable_o, .shutdown_o, .outputs_settled_o
);
`default_nettype wire

/* dv/quad_dac_host_model.sv */
// Behavioural serial master driving select, clock and data pins.
// Assumes start_i pulses once per word; done_o rises when the word is over.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_host_model
(
    input  wire logic        start_i,
    input  wire logic [15:0] word_i,
    input  wire logic        keep_high_i,
    input  wire logic        echo_i,
    output logic             chip_select_n_o,
    output logic             serial_clk_o,
    output logic             serial_data_o,
    output logic [15:0]      echo_word_o,
    output logic             done_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle pins: select high, clock parked low
    initial
    begin
        chip_select_n_o = 1'b1;
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        echo_word_o = 16'h0000;
        done_o = 1'b0;
    end
    // One word at a 160 ns clock; keep_high_i clocks with select left high
    // Data moves on the falling edge; echo is sampled just before each next rise
    always @(posedge start_i)
    begin
        done_o = 1'b0;
        chip_select_n_o = keep_high_i;
        serial_data_o = word_i[15];
        for (int i = 15; i >= 0; i--)
        begin
            #80;
            if (i != 15)
                echo_word_o = {echo_word_o[14:0], echo_i};
            serial_clk_o = 1'b1;
            #80 serial_clk_o = 1'b0;
            if (i > 0)
                serial_data_o = word_i[i-1];
        end
        #80;
        echo_word_o = {echo_word_o[14:0], echo_i};
        chip_select_n_o = 1'b1;
        // Released data line must not hold its last bit
        serial_data_o = ~serial_data_o;
        #400 done_o = 1'b1;
    end
endmodule // quad_dac_host_model
`default_nettype wire

/* dv/test_quad_dac_serial_control.sv */
// Self-checking bench for the converter serial control block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_quad_dac_serial_control;
    logic                    core_clk_i, sys_rst_i, clear_n_i, shutdown_lockout_n_i;
    logic                    chip_select_n_i, serial_clk_i, serial_data_i;
    logic                    serial_echo_o, user_logic_output_o, amp_enable_o;
    logic                    reference_pair_one_enable_o, reference_pair_two_enable_o;
    logic                    shutdown_o, outputs_settled_o, start, keep_high, done;
    logic [15:0]             word, echo_word;
    quad_dac_pkg::dac_code_t code_a_o, code_b_o, code_c_o, code_d_o;
    int                      error_cnt, n_checks;
    ////////////////////////////////////////////////////////////////////////////////
    // Short settle count keeps the wait within a few dozen cycles
    quad_dac_serial_control #(.SETTLE_CYCLES(40)) quad_dac_serial_control_i
    (
        .core_clk_i, .sys_rst_i, .chip_select_n_i, .serial_clk_i, .serial_data_i,
        .clear_n_i, .shutdown_lockout_n_i, .serial_echo_o, .user_logic_output_o,
        .code_a_o, .code_b_o, .code_c_o, .code_d_o, .amp_enable_o,
        .reference_pair_one_enable_o, .reference_pair_two_enable_o, .shutdown_o,
        .outputs_settled_o
    );
    quad_dac_host_model quad_dac_host_model_i
    (
        .start_i(start), .word_i(word), .keep_high_i(keep_high),
        .echo_i(serial_echo_o), .chip_select_n_o(chip_select_n_i),
        .serial_clk_o(serial_clk_i), .serial_data_o(serial_data_i),
        .echo_word_o(echo_word), .done_o(done)
    );
    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic ok);
        n_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: check %0d", $time, n_checks);
        end
    endtask
    // Whole word: command code, ten code bits, zero sub-bits
    task automatic send(input logic [3:0] cmd, input logic [9:0] data);
        int i;
        @(negedge core_clk_i);
        word = {cmd, data, 2'b00};
        start = 1'b1;
        @(negedge core_clk_i);
        start = 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge core_clk_i);
        if (done !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: word never finished", $time);
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_load;
        int a;
        for (a = 0; a < 4; a++)
            send({a[1:0], 2'b01}, 10'h101 + 10'(a));
        check(code_a_o === 10'h000 && code_d_o === 10'h000);
        send(4'h7, 10'h2aa);
        check({code_a_o, code_b_o, code_c_o} === {10'h101, 10'h2aa, 10'h103});
        send(4'h1, 10'h055);
        check(code_a_o === 10'h101);
        send(4'h4, 10'h000);
        check(code_a_o === 10'h055 && code_d_o === 10'h104);
        send(4'h8, 10'h3ff);
        check({code_a_o, code_b_o, code_c_o, code_d_o} === {4{10'h3ff}});
        send(4'h0, 10'h123);
        check(code_b_o === 10'h3ff && code_c_o === 10'h3ff);
    endtask
    task automatic t_modes;
        send(4'h6, 10'h000);
        check(user_logic_output_o === 1'b1);
        send(4'h2, 10'h000);
        check(user_logic_output_o === 1'b0);
        send(4'h1, 10'h000);
        send(4'he, 10'h000);
        check(code_a_o === 10'h000);
        send(4'h1, 10'h1f0);
        check(echo_word === 16'he000);
        send(4'ha, 10'h000);
        check(code_a_o === 10'h1f0);
        check(echo_word === 16'h17c0);
    endtask
    task automatic t_shutdown;
        int i;
        shutdown_lockout_n_i = 1'b0;
        send(4'hc, 10'h000);
        check(shutdown_o === 1'b0);
        check(echo_word === 16'h4001);
        shutdown_lockout_n_i = 1'b1;
        send(4'hc, 10'h000);
        check(shutdown_o === 1'b1 && amp_enable_o === 1'b0);
        check(reference_pair_one_enable_o === 1'b0 && reference_pair_two_enable_o === 1'b0);
        send(4'h9, 10'h0f0);
        check(code_c_o === 10'h3ff && shutdown_o === 1'b1);
        send(4'h4, 10'h000);
        check(shutdown_o === 1'b0 && code_c_o === 10'h0f0);
        check(outputs_settled_o === 1'b0);
        for (i = 0; i < 100 && outputs_settled_o !== 1'b1; i++)
            @(negedge core_clk_i);
        check(outputs_settled_o === 1'b1);
        send(4'hc, 10'h000);
        send(4'h8, 10'h0aa);
        check(shutdown_o === 1'b0 && code_d_o === 10'h0aa);
    endtask
    task automatic t_select_and_clear;
        keep_high = 1'b1;
        send(4'h8, 10'h001);
        keep_high = 1'b0;
        check(code_a_o === 10'h0aa && code_d_o === 10'h0aa);
        send(4'h6, 10'h000);
        clear_n_i = 1'b0;
        repeat (6) @(negedge core_clk_i);
        check({code_a_o, code_b_o, code_c_o, code_d_o} === 40'h0);
        check(user_logic_output_o === 1'b0 && serial_echo_o === 1'b0);
        clear_n_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst_i = 1'b1;
        clear_n_i = 1'b1;
        shutdown_lockout_n_i = 1'b1;
        start = 1'b0;
        keep_high = 1'b0;
        word = 16'h0000;
        error_cnt = 0;
        n_checks = 0;
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        t_load();
        t_modes();
        t_shutdown();
        t_select_and_clear();
        finish_test();
    end
endmodule // test_quad_dac_serial_control
`default_nettype wire
